// ==== hdl/data_space_access.sv ====
// data space access unit: address forming, region decode, lanes and traps
// Functional notes
// (R1) Read and write addresses are formed on separate, independent paths.
// (R2) Effective addresses are 16 bits, byte resolved, 64 Kbyte base range.
// (R3) Page register joins the base address into a 24-bit extended address.
// (R4) Only 4K special registers plus 48K ram exist; elsewhere reads zero.
// (R5) Even byte address is the low byte, odd is the high byte.
// (R6) Post-modify steps the pointer by one for bytes, two for words.
// (R7) Byte read fetches the word, bit zero picks byte, placed low.
// (R8) Lanes share one word decode; separate strobes write only addressed lane.
// (R9) Word access at an odd address raises the address error trap.
// (R10) Misaligned read completes; misaligned write is suppressed; trap follows.
// (R11) A byte loaded into a working register replaces only its low byte.
// (R12) Sign widen turns the low signed byte into a 16-bit value.
// (R13) High byte clear zeroes the upper byte of a working register.
// (R14) Addresses 0x0000 to 0x0FFF belong to the special register region.
// (R15) Unused special register addresses read as zero.
// (R16) Near direct mode reaches 0x0000 to 0x1FFF through a 13-bit field.
// (R17) Direct 16-bit field or pointer register reaches the whole space.
// (R18) Writes to unimplemented addresses are dropped silently, no error.
`timescale 1ns/1ns
`default_nettype none
module data_space_access
	import data_space_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    clk_en,
	// read address generator
	input  wire logic                    rd_req,
	input  wire logic [1:0]              rd_mode,
	input  wire logic [ADDR_W-1:0]       rd_ptr,
	input  wire logic [ADDR_W-1:0]       rd_field,
	input  wire logic                    rd_byte,
	output logic                         rd_valid,
	output logic      [DATA_W-1:0]       rd_data,
	output logic      [ADDR_W-1:0]       rd_post_addr,
	output logic      [EXT_W-1:0]        rd_ext_addr,
	// write address generator
	input  wire logic                    wr_req,
	input  wire logic [1:0]              wr_mode,
	input  wire logic [ADDR_W-1:0]       wr_ptr,
	input  wire logic [ADDR_W-1:0]       wr_field,
	input  wire logic                    wr_byte,
	input  wire logic [DATA_W-1:0]       wr_data,
	output logic                         wr_done,
	output logic      [ADDR_W-1:0]       wr_post_addr,
	output logic      [EXT_W-1:0]        wr_ext_addr,
	// page registers
	input  wire logic                    rd_page_load,
	input  wire logic                    wr_page_load,
	input  wire logic [PAGE_W-1:0]       page_value,
	// special register region
	output logic      [ADDR_W-1:0]       sfr_rd_addr,
	output logic                         sfr_rd_en,
	input  wire logic [DATA_W-1:0]       sfr_rd_data,
	input  wire logic                    sfr_rd_hit,
	output logic      [ADDR_W-1:0]       sfr_wr_addr,
	output logic      [LANES-1:0]        sfr_wr_lanes,
	output logic      [DATA_W-1:0]       sfr_wr_data,
	// working register operations
	input  wire logic                    wreg_op_req,
	input  wire logic [1:0]              wreg_op,
	input  wire logic [DATA_W-1:0]       wreg_old,
	input  wire logic [BYTE_W-1:0]       wreg_byte,
	output logic                         wreg_valid,
	output logic      [DATA_W-1:0]       wreg_result,
	// address error trap
	output logic                         addr_trap,
	output logic                         addr_trap_write,
	output logic      [ADDR_W-1:0]       addr_trap_ea
);
	// ==========================================================
	// decode helpers, used by both paths
	function automatic logic [ADDR_W-1:0] ea_form(input logic [1:0] mode,
			input logic [ADDR_W-1:0] ptr, input logic [ADDR_W-1:0] field);
		logic [ADDR_W-1:0] ea;
		ea = ptr;
		case (mode)
			MODE_NEAR:   ea = {3'h0, field[NEAR_FIELD_W-1:0]}; // see (R16)
			MODE_DIRECT: ea = field;                           // see (R17)
			default:     ea = ptr;                             // see (R17)
		endcase
		return ea;
	endfunction : ea_form

	function automatic logic [1:0] region_of(input logic [ADDR_W-1:0] ea);
		logic [1:0] r;
		r = REGION_NONE;
		if (ea <= SFR_LAST) begin
			r = REGION_SFR;                      // see (R14)
		end else if (ea >= RAM_BASE && ea <= RAM_LAST) begin
			r = REGION_RAM;
		end
		return r;                                // see (R4)
	endfunction : region_of

	function automatic logic [RAM_IDX_W-1:0] ram_index(input logic [ADDR_W-1:0] ea);
		logic [ADDR_W-1:0] off;
		off = ea - RAM_BASE;
		return off[ADDR_W-1:1];                  // see (R8)
	endfunction : ram_index

	// ==========================================================
	// read path decode, independent of the write path
	logic [ADDR_W-1:0]  rd_ea;
	logic [1:0]         rd_region;
	logic               rd_misalign;
	logic [DATA_W-1:0]  ram_rd_word;
	logic [DATA_W-1:0]  rd_word;
	logic [DATA_W-1:0]  rd_data_next;

	always_comb begin
		rd_ea       = ea_form(rd_mode, rd_ptr, rd_field);       // see (R1) (R2)
		rd_region   = region_of(rd_ea);
		rd_misalign = !rd_byte && rd_ea[0];                     // see (R9)
	end

	// source word; absent locations answer zero
	always_comb begin
		case (rd_region)
			REGION_SFR: rd_word = sfr_rd_hit ? sfr_rd_data : WORD_ZERO; // see (R15)
			REGION_RAM: rd_word = ram_rd_word;
			default:    rd_word = WORD_ZERO;                          // see (R4)
		endcase
	end

	// whole word fetched, byte picked by bit zero onto the low lane
	always_comb begin
		if (rd_byte) begin
			rd_data_next = {BYTE_ZERO, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]}; // see (R5) (R7)
		end else begin
			rd_data_next = rd_word; // misaligned word still completes, see (R10)
		end
	end

	assign sfr_rd_addr = {rd_ea[ADDR_W-1:1], 1'b0};
	assign sfr_rd_en   = rd_req && (rd_region == REGION_SFR);

	// ==========================================================
	// write path decode
	logic [ADDR_W-1:0]  wr_ea;
	logic [1:0]         wr_region;
	logic               wr_misalign;
	logic [LANES-1:0]   wr_lanes_raw;
	logic [LANES-1:0]   wr_lanes;
	logic [LANES-1:0]   ram_wr_lanes;
	logic [DATA_W-1:0]  wr_word;

	always_comb begin
		wr_ea       = ea_form(wr_mode, wr_ptr, wr_field);       // see (R1) (R2)
		wr_region   = region_of(wr_ea);
		wr_misalign = !wr_byte && wr_ea[0];                     // see (R9)
	end

	// byte data rides on both lanes; the strobe decides which one lands
	always_comb begin
		if (wr_byte) begin
			wr_lanes_raw = wr_ea[0] ? LANE_HIGH : LANE_LOW;     // see (R5) (R8)
			wr_word      = {wr_data[7:0], wr_data[7:0]};
		end else begin
			wr_lanes_raw = LANE_BOTH;
			wr_word      = wr_data;
		end
		// a misaligned word write executes but never reaches storage
		wr_lanes = (wr_req && !wr_misalign) ? wr_lanes_raw : LANE_NONE; // see (R10)
	end

	// outside both regions the strobes stay low: silently dropped
	assign ram_wr_lanes = (wr_region == REGION_RAM) ? wr_lanes : LANE_NONE; // see (R18)

	// ==========================================================
	// ram array
	lane_store u_ram (
		.clk_sys  (clk_sys),
		.clk_en   (clk_en),
		.wr_lanes (ram_wr_lanes),
		.wr_index (ram_index(wr_ea)),
		.wr_word  (wr_word),
		.rd_index (ram_index(rd_ea)),
		.rd_word  (ram_rd_word)
	);

	// ==========================================================
	// special register writes, presented one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sfr_wr_addr  <= WORD_ZERO;
			sfr_wr_lanes <= LANE_NONE;
			sfr_wr_data  <= WORD_ZERO;
		end else if (clk_en) begin
			sfr_wr_addr  <= {wr_ea[ADDR_W-1:1], 1'b0};
			sfr_wr_lanes <= (wr_region == REGION_SFR) ? wr_lanes : LANE_NONE; // see (R8)
			sfr_wr_data  <= wr_word;
		end
	end

	// ==========================================================
	// page registers
	logic [PAGE_W-1:0] read_page_reg;
	logic [PAGE_W-1:0] write_page_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			read_page_reg  <= PAGE_RESET;
			write_page_reg <= PAGE_RESET;
		end else if (clk_en) begin
			if (rd_page_load) begin
				read_page_reg <= page_value;
			end
			if (wr_page_load) begin
				write_page_reg <= page_value;
			end
		end
	end

	// ==========================================================
	// read results and post-modified pointer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_valid     <= 1'b0;
			rd_data      <= WORD_ZERO;
			rd_post_addr <= WORD_ZERO;
			rd_ext_addr  <= '0;
		end else if (clk_en) begin
			rd_valid <= rd_req;
			if (rd_req) begin
				rd_data      <= rd_data_next;
				rd_post_addr <= rd_ea + (rd_byte ? STEP_BYTE : STEP_WORD); // see (R6)
				rd_ext_addr  <= {read_page_reg, rd_ea};                    // see (R3)
			end
		end
	end

	// ==========================================================
	// write completion and post-modified pointer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_done      <= 1'b0;
			wr_post_addr <= WORD_ZERO;
			wr_ext_addr  <= '0;
		end else if (clk_en) begin
			wr_done <= wr_req;
			if (wr_req) begin
				wr_post_addr <= wr_ea + (wr_byte ? STEP_BYTE : STEP_WORD); // see (R6)
				wr_ext_addr  <= {write_page_reg, wr_ea};                   // see (R3)
			end
		end
	end

	// ==========================================================
	// address error trap; a write fault wins the address report,
	// since the suppressed write is the one software must redo
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			addr_trap       <= 1'b0;
			addr_trap_write <= 1'b0;
			addr_trap_ea    <= WORD_ZERO;
		end else if (clk_en) begin
			addr_trap <= (rd_req && rd_misalign) || (wr_req && wr_misalign); // see (R9) (R10)
			if (wr_req && wr_misalign) begin
				addr_trap_write <= 1'b1;
				addr_trap_ea    <= wr_ea;
			end else if (rd_req && rd_misalign) begin
				addr_trap_write <= 1'b0;
				addr_trap_ea    <= rd_ea;
			end
		end
	end

	// ==========================================================
	// working register operations
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wreg_valid  <= 1'b0;
			wreg_result <= WORD_ZERO;
		end else if (clk_en) begin
			wreg_valid <= wreg_op_req;
			if (wreg_op_req) begin
				case (wreg_op)
					OP_BYTE_LOAD:  wreg_result <= {wreg_old[15:8], wreg_byte};        // see (R11)
					OP_SIGN_WIDEN: wreg_result <= {{8{wreg_old[7]}}, wreg_old[7:0]};  // see (R12)
					OP_HIGH_CLEAR: wreg_result <= {BYTE_ZERO, wreg_old[7:0]};         // see (R13)
					default:       wreg_result <= wreg_old;
				endcase
			end
		end
	end

	// ==========================================================
	// checks
	a_read_latency: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R1)
		clk_en && rd_req |=> rd_valid)
		else $error("read answer missing one cycle after request");

	a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R4)
		clk_en && rd_req && rd_region == REGION_NONE |=> rd_data == WORD_ZERO)
		else $error("unimplemented read not zero");

	a_byte_low_lane: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R7)
		clk_en && rd_req && rd_byte |=> rd_data[15:8] == BYTE_ZERO)
		else $error("byte read not on low lane");

	a_misalign_trap: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R9)
		clk_en && ((rd_req && !rd_byte && rd_ea[0]) || (wr_req && !wr_byte && wr_ea[0]))
		|=> addr_trap)
		else $error("misaligned word gave no trap");

	a_aligned_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R9)
		clk_en && !(rd_req && rd_misalign) && !(wr_req && wr_misalign) |=> !addr_trap)
		else $error("trap without misaligned access");

	a_write_suppress: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R10)
		clk_en && wr_req && !wr_byte && wr_ea[0]
		|-> ram_wr_lanes == LANE_NONE ##1 sfr_wr_lanes == LANE_NONE)
		else $error("misaligned write reached storage");

	a_byte_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R8)
		wr_req && wr_byte && wr_region == REGION_RAM
		|-> ram_wr_lanes == (wr_ea[0] ? LANE_HIGH : LANE_LOW))
		else $error("byte write strobed wrong lane");

	a_unimpl_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R18)
		clk_en && wr_req && wr_region == REGION_NONE && !wr_misalign && !rd_misalign
		|-> ram_wr_lanes == LANE_NONE ##1 sfr_wr_lanes == LANE_NONE && !addr_trap)
		else $error("unimplemented write not silently dropped");

	a_post_step: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R6)
		clk_en && rd_req |=> rd_post_addr == $past(rd_ea) + ($past(rd_byte) ? 16'h0001 : 16'h0002))
		else $error("post-modify step wrong");

	a_sign_widen: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R12)
		clk_en && wreg_op_req && wreg_op == OP_SIGN_WIDEN
		|=> wreg_result[15:8] == {8{$past(wreg_old[7])}})
		else $error("sign widen upper byte wrong");

	a_byte_merge: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R11)
		clk_en && wreg_op_req && wreg_op == OP_BYTE_LOAD
		|=> wreg_result == {$past(wreg_old[15:8]), $past(wreg_byte)})
		else $error("byte load disturbed high byte");
endmodule : data_space_access
`default_nettype wire

// ==== hdl/data_space_pkg.sv ====
// constants shared by the data space access unit and its lane store
package data_space_pkg;
	// ==========================================================
	// widths
	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 16;
	localparam int BYTE_W       = 8;
	localparam int PAGE_W       = 8;
	localparam int EXT_W        = 24;
	localparam int NEAR_FIELD_W = 13;
	localparam int LANES        = 2;
	// ==========================================================
	// address map, byte addresses
	localparam logic [15:0] SFR_BASE  = 16'h0000;
	localparam logic [15:0] SFR_LAST  = 16'h0FFF;
	localparam logic [15:0] RAM_BASE  = 16'h1000;
	localparam logic [15:0] RAM_LAST  = 16'hCFFF;
	localparam logic [15:0] NEAR_LAST = 16'h1FFF;
	localparam int          RAM_WORDS = 24576;
	localparam int          RAM_IDX_W = 15;
	// ==========================================================
	// post-modify steps
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	// ==========================================================
	// addressing modes
	localparam logic [1:0] MODE_INDIRECT = 2'h0;
	localparam logic [1:0] MODE_NEAR     = 2'h1;
	localparam logic [1:0] MODE_DIRECT   = 2'h2;
	// ==========================================================
	// region codes
	localparam logic [1:0] REGION_SFR  = 2'h0;
	localparam logic [1:0] REGION_RAM  = 2'h1;
	localparam logic [1:0] REGION_NONE = 2'h2;
	// ==========================================================
	// working register operations
	localparam logic [1:0] OP_BYTE_LOAD  = 2'h0;
	localparam logic [1:0] OP_SIGN_WIDEN = 2'h1;
	localparam logic [1:0] OP_HIGH_CLEAR = 2'h2;
	// ==========================================================
	// lane strobes, reset values and timing
	localparam logic [1:0]  LANE_LOW   = 2'h1;
	localparam logic [1:0]  LANE_HIGH  = 2'h2;
	localparam logic [1:0]  LANE_BOTH  = 2'h3;
	localparam logic [1:0]  LANE_NONE  = 2'h0;
	localparam logic [7:0]  PAGE_RESET = 8'h00;
	localparam logic [15:0] WORD_ZERO  = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam int          RD_LATENCY = 1;
endpackage : data_space_pkg

// ==== hdl/lane_store.sv ====
// two byte-wide ram lanes with shared word index and separate write strobes
`timescale 1ns/1ns
`default_nettype none
module lane_store
	import data_space_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   clk_en,
	input  wire logic [LANES-1:0]       wr_lanes,
	input  wire logic [RAM_IDX_W-1:0]   wr_index,
	input  wire logic [DATA_W-1:0]      wr_word,
	input  wire logic [RAM_IDX_W-1:0]   rd_index,
	output logic      [DATA_W-1:0]      rd_word
);
	// ==========================================================
	// one array per lane; the read is combinational so the caller
	// can register the selected byte in the same cycle
	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			logic [BYTE_W-1:0] mem [RAM_WORDS];
			// only the strobed lane is written
			always_ff @(posedge clk_sys) begin
				if (clk_en && wr_lanes[lane]) begin
					mem[wr_index] <= wr_word[lane*BYTE_W +: BYTE_W];
				end
			end
			assign rd_word[lane*BYTE_W +: BYTE_W] = mem[rd_index];
		end
	endgenerate
endmodule : lane_store
`default_nettype wire

// ==== verification/sfr_region_model.sv ====
// behavioural special register region that answers the access unit
`timescale 1ns/1ns
`default_nettype none
module sfr_region_model
	import data_space_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic [ADDR_W-1:0] sfr_rd_addr,
	input  wire logic              sfr_rd_en,
	output logic      [DATA_W-1:0] sfr_rd_data,
	output logic                   sfr_rd_hit,
	input  wire logic [ADDR_W-1:0] sfr_wr_addr,
	input  wire logic [LANES-1:0]  sfr_wr_lanes,
	input  wire logic [DATA_W-1:0] sfr_wr_data
);
	// ==========================================================
	// storage
	logic [DATA_W-1:0] regs [0:1023];
	logic [DATA_W-1:0] noise_reg;
	// only the lower half is populated, the upper half is unused space
	assign sfr_rd_hit  = sfr_rd_en && (sfr_rd_addr < 16'h0800);
	// unused or idle: a changing pattern, so a zero answer is the unit's own doing
	assign sfr_rd_data = sfr_rd_hit ? regs[sfr_rd_addr[10:1]] : noise_reg;
	// lane strobes update only their own byte
	always @(posedge clk_sys) begin
		noise_reg <= ~noise_reg + 16'h0013;
		if (sfr_wr_lanes[0])
			regs[sfr_wr_addr[10:1]][7:0] <= sfr_wr_data[7:0];
		if (sfr_wr_lanes[1])
			regs[sfr_wr_addr[10:1]][15:8] <= sfr_wr_data[15:8];
	end
	initial noise_reg = 16'h5A3C;
endmodule : sfr_region_model
`default_nettype wire

// ==== verification/test_data_space_access.sv ====
// self-checking bench for the data space access unit
`timescale 1ns/1ns
`default_nettype none
module test_data_space_access;
	import data_space_pkg::*;
	// ==========================================================
	// signals
	logic clk_sys = 0, sys_rst = 1, clk_en = 1;
	logic rd_req = 0, rd_byte = 0, wr_req = 0, wr_byte = 0;
	logic [1:0] rd_mode = 0, wr_mode = 0, wreg_op = 0;
	logic [15:0] rd_ptr = 0, rd_field = 0, wr_ptr = 0, wr_field = 0, wr_data = 0;
	logic rd_page_load = 0, wr_page_load = 0, wreg_op_req = 0;
	logic [7:0] page_value = 0, wreg_byte = 0;
	logic [15:0] wreg_old = 0;
	logic rd_valid, wr_done, sfr_rd_en, sfr_rd_hit, wreg_valid, addr_trap, addr_trap_write;
	logic [15:0] rd_data, rd_post_addr, wr_post_addr, sfr_rd_addr, sfr_rd_data;
	logic [15:0] sfr_wr_addr, sfr_wr_data, wreg_result, addr_trap_ea;
	logic [23:0] rd_ext_addr, wr_ext_addr;
	logic [1:0] sfr_wr_lanes;
	int n_fail = 0, checks_done = 0;
	always #4 clk_sys = ~clk_sys;
	data_space_access uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
		.rd_req(rd_req), .rd_mode(rd_mode), .rd_ptr(rd_ptr), .rd_field(rd_field),
		.rd_byte(rd_byte), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_post_addr(rd_post_addr), .rd_ext_addr(rd_ext_addr), .wr_req(wr_req),
		.wr_mode(wr_mode), .wr_ptr(wr_ptr), .wr_field(wr_field), .wr_byte(wr_byte),
		.wr_data(wr_data), .wr_done(wr_done), .wr_post_addr(wr_post_addr),
		.wr_ext_addr(wr_ext_addr), .rd_page_load(rd_page_load),
		.wr_page_load(wr_page_load), .page_value(page_value), .sfr_rd_addr(sfr_rd_addr),
		.sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit),
		.sfr_wr_addr(sfr_wr_addr), .sfr_wr_lanes(sfr_wr_lanes), .sfr_wr_data(sfr_wr_data),
		.wreg_op_req(wreg_op_req), .wreg_op(wreg_op), .wreg_old(wreg_old),
		.wreg_byte(wreg_byte), .wreg_valid(wreg_valid), .wreg_result(wreg_result),
		.addr_trap(addr_trap), .addr_trap_write(addr_trap_write),
		.addr_trap_ea(addr_trap_ea));
	sfr_region_model partner (.clk_sys(clk_sys), .sfr_rd_addr(sfr_rd_addr),
		.sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit),
		.sfr_wr_addr(sfr_wr_addr), .sfr_wr_lanes(sfr_wr_lanes), .sfr_wr_data(sfr_wr_data));
	// ==========================================================
	// shared tasks: compare, read, write, register op
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// request raised at a falling edge, answers sampled one cycle later
	task automatic rd(input logic [1:0] m, input logic [15:0] p, input logic [15:0] f,
			input logic b);
		@(negedge clk_sys);
		rd_req = 1; rd_mode = m; rd_ptr = p; rd_field = f; rd_byte = b;
		@(negedge clk_sys);
		rd_req = 0;
		chk(rd_valid, 1, "read valid");
	endtask : rd
	// the region model commits at the edge after the check, before any later read
	task automatic wr(input logic [1:0] m, input logic [15:0] p, input logic b,
			input logic [15:0] d);
		@(negedge clk_sys);
		wr_req = 1; wr_mode = m; wr_ptr = p; wr_field = p; wr_byte = b; wr_data = d;
		@(negedge clk_sys);
		wr_req = 0;
		chk(wr_done, 1, "write done");
	endtask : wr
	task automatic wop(input logic [1:0] op, input logic [15:0] old, input logic [7:0] by,
			input logic [15:0] exp);
		@(negedge clk_sys);
		wreg_op_req = 1; wreg_op = op; wreg_old = old; wreg_byte = by;
		@(negedge clk_sys);
		wreg_op_req = 0;
		chk(wreg_valid, 1, "wreg valid");
		chk(wreg_result, exp, "wreg result");
	endtask : wop
	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk(rd_valid | wr_done | addr_trap | wreg_valid, 0, "strobes after reset");
		chk(rd_data, 0, "rd_data after reset");
		$display("test reset done");
	endtask : t_reset
	task automatic t_ram_word;
		wr(MODE_INDIRECT, 16'h1234, 0, 16'hA55A);
		chk(wr_post_addr, 16'h1236, "write post step");
		chk(wr_ext_addr, 24'h00_1234, "write ext reset page");
		chk(addr_trap, 0, "aligned write no trap");
		@(negedge clk_sys);
		rd_page_load = 1;
		wr_page_load = 1;
		page_value = 8'h5A;
		@(negedge clk_sys);
		rd_page_load = 0;
		wr_page_load = 0;
		rd(MODE_DIRECT, 16'h0000, 16'h1234, 0);
		chk(rd_data, 16'hA55A, "word readback");
		chk(rd_post_addr, 16'h1236, "read post step");
		chk(rd_ext_addr, 24'h5A_1234, "read ext page");
		wr(MODE_DIRECT, 16'hCFFE, 0, 16'h7E81);
		chk(wr_ext_addr, 24'h5A_CFFE, "write ext page");
		rd(MODE_INDIRECT, 16'hCFFE, 16'h0000, 0);
		chk(rd_data, 16'h7E81, "top ram word");
		$display("test ram word done");
	endtask : t_ram_word
	task automatic t_lanes;
		wr(MODE_INDIRECT, 16'h1235, 1, 16'h00C3);
		chk(wr_post_addr, 16'h1236, "byte write step");
		rd(MODE_INDIRECT, 16'h1234, 16'h0000, 0);
		chk(rd_data, 16'hC35A, "odd byte to high lane");
		rd(MODE_INDIRECT, 16'h1235, 16'h0000, 1);
		chk(rd_data, 16'h00C3, "odd byte on low lane");
		chk(rd_post_addr, 16'h1236, "byte read step");
		rd(MODE_INDIRECT, 16'h1234, 16'h0000, 1);
		chk(rd_data, 16'h005A, "even byte on low lane");
		rd(2'h3, 16'h1234, 16'h0000, 0);
		chk(rd_data, 16'hC35A, "mode three uses pointer");
		$display("test lanes done");
	endtask : t_lanes
	task automatic t_misalign;
		wr(MODE_INDIRECT, 16'h1235, 0, 16'hFFFF);
		chk({addr_trap, addr_trap_write}, 2'b11, "write trap");
		chk(addr_trap_ea, 16'h1235, "write trap ea");
		@(negedge clk_sys);
		rd(MODE_INDIRECT, 16'h1234, 16'h0000, 0);
		chk(rd_data, 16'hC35A, "suppressed write");
		rd(MODE_INDIRECT, 16'h1235, 16'h0000, 0);
		chk({addr_trap, addr_trap_write}, 2'b10, "read trap");
		chk(addr_trap_ea, 16'h1235, "read trap ea");
		chk(rd_data, 16'hC35A, "read completes");
		$display("test misalign done");
	endtask : t_misalign
	task automatic t_unimpl;
		wr(MODE_INDIRECT, 16'hD000, 0, 16'h1111);
		chk(addr_trap, 0, "dropped write no trap");
		chk(sfr_wr_lanes, LANE_NONE, "no lanes outside");
		rd(MODE_INDIRECT, 16'hD000, 16'h0000, 0);
		chk(rd_data, WORD_ZERO, "unimplemented word");
		rd(MODE_INDIRECT, 16'hFFFF, 16'h0000, 1);
		chk(rd_data, WORD_ZERO, "unimplemented byte");
		$display("test unimplemented done");
	endtask : t_unimpl
	task automatic t_sfr;
		wr(MODE_INDIRECT, 16'h0100, 0, 16'hBEEF);
		chk(sfr_wr_lanes, LANE_BOTH, "sfr word lanes");
		chk(sfr_wr_addr, 16'h0100, "sfr write addr");
		chk(sfr_wr_data, 16'hBEEF, "sfr write data");
		wr(MODE_INDIRECT, 16'h0101, 1, 16'h0012);
		chk(sfr_wr_lanes, LANE_HIGH, "sfr odd lane");
		@(negedge clk_sys);
		rd(MODE_NEAR, 16'h0000, 16'hE100, 0);
		chk(rd_data, 16'h12EF, "sfr near read");
		chk(rd_ext_addr[15:0], 16'h0100, "near ea truncated");
		rd(MODE_INDIRECT, 16'h0900, 16'h0000, 0);
		chk(rd_data, WORD_ZERO, "unused sfr");
		$display("test sfr done");
	endtask : t_sfr
	task automatic t_wreg;
		wop(OP_BYTE_LOAD, 16'h9911, 8'h7E, 16'h997E);
		wop(OP_SIGN_WIDEN, 16'h3380, 8'h80, 16'hFF80);
		wop(OP_SIGN_WIDEN, 16'hC37F, 8'h7F, 16'h007F);
		wop(OP_HIGH_CLEAR, 16'hABCD, 8'hCD, 16'h00CD);
		wop(2'h3, 16'h5AA5, 8'h00, 16'h5AA5);
		$display("test wreg done");
	endtask : t_wreg
	// a write offered while the enable is low must neither land nor answer
	task automatic t_freeze;
		@(negedge clk_sys);
		clk_en = 0;
		wr_req = 1;
		wr_mode = MODE_INDIRECT;
		wr_ptr = 16'h1234;
		wr_byte = 0;
		wr_data = 16'h0000;
		@(negedge clk_sys);
		chk(wr_done, 0, "frozen write answered");
		wr_req = 0;
		clk_en = 1;
		rd(MODE_INDIRECT, 16'h1234, 16'h0000, 0);
		chk(rd_data, 16'hC35A, "frozen write landed");
		$display("test freeze done");
	endtask : t_freeze
	// ==========================================================
	// verdict, one place for both the normal end and the watchdog
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(negedge clk_sys);
		sys_rst = 0;
		t_reset();
		t_ram_word();
		t_lanes();
		t_misalign();
		t_unimpl();
		t_sfr();
		t_wreg();
		t_freeze();
		tally_and_finish();
	end
	// the whole sequence needs well under 200 cycles
	initial begin
		#20000;
		n_fail++;
		tally_and_finish();
	end
endmodule : test_data_space_access
`default_nettype wire
